// ===== design/rrf_pkg.sv
// Shared constants and types for the raw framer and power control
`default_nettype none
package rrf_pkg;
	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_POWER  = 8'h04;
	localparam logic [7:0] A_PRE    = 8'h08;
	localparam logic [7:0] A_PLEN   = 8'h0c;
	localparam logic [7:0] A_DATA   = 8'h10;
	localparam logic [7:0] A_STAT   = 8'h14;
	localparam logic [7:0] A_GAIN   = 8'h18;
	localparam logic [7:0] A_AMPL   = 8'h1c;
	localparam logic [7:0] A_FREQ   = 8'h20;
	localparam logic [7:0] A_PERIOD = 8'h24;
	localparam logic [7:0] A_BRATE  = 8'h28;
	localparam logic [7:0] A_DEV    = 8'h2c;
	// ----------------------------------------------------------------
	// Field codes and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] FR_RAW  = 2'h0;
	localparam logic [1:0] FR_PRE  = 2'h1;
	localparam logic [1:0] FR_DSSS = 2'h2;
	localparam logic [1:0] MOD_ASK = 2'h0;
	localparam logic [1:0] MOD_FSK = 2'h1;
	localparam logic [1:0] MOD_PSK = 2'h2;
	localparam logic [1:0] MOD_MSK = 2'h3;
	localparam logic [3:0] PW_DOWN = 4'h0;
	localparam logic [3:0] PW_REG  = 4'h4;
	localparam logic [3:0] PW_STBY = 4'h5;
	localparam logic [3:0] PW_SRX  = 4'h8;
	localparam logic [3:0] PW_FRX  = 4'h9;
	localparam logic [3:0] PW_STX  = 4'hc;
	localparam logic [3:0] PW_FTX  = 4'hd;
	localparam logic [3:0] CHIP_LAST = 4'he;
	localparam logic [14:0] PN_SEQ = 15'h09af;
	localparam logic [3:0] LOCK_HI = 4'he;
	localparam logic [3:0] LOCK_LO = 4'h1;
	localparam logic [3:0] KEEP_HI = 4'hb;
	localparam logic [3:0] KEEP_LO = 4'h4;
	localparam logic [3:0] HALF_M  = 4'h8;
	localparam logic [31:0] DSSS_PRE = 32'h000000a7;
	localparam logic [5:0] PLEN_MIN = 6'h04;
	localparam logic [5:0] PLEN_MAX = 6'h20;
	localparam logic [31:0] RST_PRE = 32'haaaaaaab;
	localparam logic [15:0] RST_PERIOD = 16'h0064;
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	typedef enum logic [6:0] {
		PS_DOWN = 7'h01,
		PS_REG  = 7'h02,
		PS_STBY = 7'h04,
		PS_SRX  = 7'h08,
		PS_FRX  = 7'h10,
		PS_STX  = 7'h20,
		PS_FTX  = 7'h40
	} rrf_pwr_type;

	function automatic rrf_pwr_type pwr_decode(input logic [3:0] c);
		case (c)
			PW_REG:  pwr_decode = PS_REG;
			PW_STBY: pwr_decode = PS_STBY;
			PW_SRX:  pwr_decode = PS_SRX;
			PW_FRX:  pwr_decode = PS_FRX;
			PW_STX:  pwr_decode = PS_STX;
			PW_FTX:  pwr_decode = PS_FTX;
			default: pwr_decode = PS_DOWN;
		endcase
	endfunction
endpackage
`default_nettype wire

// ===== design/rrf_deser.sv
// Receive bit grouping with optional preamble alignment
`default_nettype none
module rrf_deser (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        flush,
	input  wire logic        pre_mode,
	input  wire logic        bit_stb,
	input  wire logic        bit_val,
	input  wire logic [31:0] pattern,
	input  wire logic [5:0]  plen,
	output logic             byte_stb,
	output logic [7:0]       byte_val,
	output logic             synced
);
	logic [31:0] sh;
	logic [31:0] nsh;
	logic [31:0] mask;
	logic [2:0]  cnt;

	always_comb begin
		nsh  = {sh[30:0], bit_val};
		mask = 32'hffffffff >> (6'h20 - plen);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sh       <= 32'h00000000;
			cnt      <= 3'h0;
			synced   <= 1'b0;
			byte_stb <= 1'b0;
			byte_val <= 8'h00;
		end else begin
			byte_stb <= 1'b0;
			if (flush) begin
				synced <= 1'b0;
				cnt    <= 3'h0;
			end else if (bit_stb) begin
				sh <= nsh;
				if (pre_mode && !synced) begin
					if (((nsh ^ pattern) & mask) == 32'h00000000) begin
						synced <= 1'b1;
						cnt    <= 3'h0;
					end
				end else begin
					cnt <= cnt + 3'h1;
					if (cnt == 3'h7) begin
						byte_stb <= 1'b1;
						byte_val <= nsh[7:0];
					end
				end
			end
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_pre_gate;
		pre_mode && !synced |=> !byte_stb;
	endproperty
	a_pre_gate: assert property (p_pre_gate) else $error("byte before preamble");
endmodule
`default_nettype wire

// ===== design/rrf_despread.sv
// Chip despreader: sliding correlation, then fixed 15-chip symbols
`default_nettype none
module rrf_despread (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic flush,
	input  wire logic chip_stb,
	input  wire logic chip_val,
	output logic      bit_stb,
	output logic      bit_val
);
	logic [14:0] win;
	logic [14:0] nwin;
	logic [3:0]  cnt;
	logic [3:0]  m;
	logic        locked;

	function automatic logic [3:0] pop15(input logic [14:0] v);
		pop15 = 4'h0;
		for (int i = 0; i < 15; i++) begin
			pop15 = pop15 + {3'h0, v[i]};
		end
	endfunction

	always_comb begin
		nwin = {win[13:0], chip_val};
		m    = 4'hf - pop15(nwin ^ rrf_pkg::PN_SEQ);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			win     <= 15'h0000;
			cnt     <= 4'h0;
			locked  <= 1'b0;
			bit_stb <= 1'b0;
			bit_val <= 1'b0;
		end else begin
			bit_stb <= 1'b0;
			if (flush) begin
				locked <= 1'b0;
				cnt    <= 4'h0;
			end else if (chip_stb) begin
				win <= nwin;
				// 15 chips back to one bit
				if (!locked) begin
					if (m >= rrf_pkg::LOCK_HI || m <= rrf_pkg::LOCK_LO) begin
						locked  <= 1'b1;
						cnt     <= 4'h0;
						bit_stb <= 1'b1;
						bit_val <= m <= rrf_pkg::LOCK_LO;
					end
				end else if (cnt == rrf_pkg::CHIP_LAST) begin
					cnt     <= 4'h0;
					bit_stb <= 1'b1;
					bit_val <= m < rrf_pkg::HALF_M;
					locked  <= m >= rrf_pkg::KEEP_HI || m <= rrf_pkg::KEEP_LO;
				end else begin
					cnt <= cnt + 4'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== design/rrf_radio_framer.sv
// Raw framer, spreader, modulator mapping and power state control
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`default_nettype none
module rrf_radio_framer (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	output logic             tx_bit,
	output logic             tx_bit_valid,
	output logic             pa_on,
	output logic             freq_dev_pos,
	output logic             phase_180,
	output logic [15:0]      deviation_word,
	output logic             supply_rail_nominal,
	output logic             xtal_on,
	output logic             synth_on,
	output logic             synth_tx_freq,
	output logic             rx_on,
	output logic             tx_on,
	input  wire logic        rx_bit,
	input  wire logic        rx_bit_valid,
	input  wire logic [7:0]  gain_level_reading,
	input  wire logic [15:0] post_filter_amplitude,
	input  wire logic [15:0] frequency_offset_track
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [1:0]  frame_mode;
	logic [1:0]  mod_sel;
	logic [3:0]  power_state_select;
	rrf_pkg::rrf_pwr_type pwr_state;
	rrf_pkg::rrf_pwr_type next_pwr;
	logic [31:0] pre_pat;
	logic [5:0]  pre_len;
	logic [15:0] period;
	logic [15:0] brate;
	logic [15:0] fdev;
	logic [15:0] div_cnt;
	logic [15:0] next_div;
	logic        bit_tick;
	logic [7:0]  wa;
	logic [31:0] wd;
	logic [3:0]  ws;
	logic        do_wr;
	logic [31:0] next_rdata;
	logic [7:0]  tx_hold;
	logic [7:0]  tx_sh;
	logic [3:0]  tx_left;
	logic [3:0]  chip_idx;
	logic        tx_full;
	logic        tx_busy;
	logic        cur_chip;
	logic [7:0]  rx_data;
	logic        rx_valid;
	logic        pop;
	logic        index_ok;
	logic        dsss;
	logic        flush;
	logic        dsp_stb;
	logic        dsp_bit;
	logic        byte_stb;
	logic [7:0]  byte_val;
	logic        synced;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				merge[8*i +: 8] = d[8*i +: 8];
			end
		end
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = a <= rrf_pkg::A_DEV && a[1:0] == 2'h0;
	endfunction

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	assign do_wr = !awready && !wready && !bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready  <= 1'b1;
			bvalid  <= 1'b0;
			bresp   <= rrf_pkg::RESP_OK;
			wa      <= 8'h00;
			wd      <= 32'h00000000;
			ws      <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				wa      <= awaddr;
			end
			if (wvalid && wready) begin
				wready <= 1'b0;
				wd     <= wdata;
				ws     <= wstrb;
			end
			if (do_wr) begin
				bvalid <= 1'b1;
				bresp  <= mapped(wa) ? rrf_pkg::RESP_OK : rrf_pkg::RESP_ERR;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	always_comb begin
		next_rdata = 32'h00000000;
		if (araddr == rrf_pkg::A_CTRL) begin
			next_rdata = {28'h0000000, mod_sel, frame_mode};
		end else if (araddr == rrf_pkg::A_POWER) begin
			next_rdata = {28'h0000000, power_state_select};
		end else if (araddr == rrf_pkg::A_PRE) begin
			next_rdata = pre_pat;
		end else if (araddr == rrf_pkg::A_PLEN) begin
			next_rdata = {26'h0000000, pre_len};
		end else if (araddr == rrf_pkg::A_DATA) begin
			next_rdata = {24'h000000, rx_data};
		end else if (araddr == rrf_pkg::A_STAT) begin
			next_rdata = {17'h00000, pwr_state, 3'h0, index_ok, synced,
				tx_busy, tx_full, rx_valid};
		end else if (araddr == rrf_pkg::A_GAIN) begin
			// gain count, 0.625 dB a step
			next_rdata = {24'h000000, gain_level_reading};
		end else if (araddr == rrf_pkg::A_AMPL) begin
			next_rdata = {16'h0000, post_filter_amplitude};
		end else if (araddr == rrf_pkg::A_FREQ) begin
			next_rdata = {{16{frequency_offset_track[15]}},
				frequency_offset_track};
		end else if (araddr == rrf_pkg::A_PERIOD) begin
			next_rdata = {16'h0000, period};
		end else if (araddr == rrf_pkg::A_BRATE) begin
			next_rdata = {16'h0000, brate};
		end else if (araddr == rrf_pkg::A_DEV) begin
			next_rdata = {16'h0000, fdev};
		end
	end

	assign pop = arvalid && arready && araddr == rrf_pkg::A_DATA;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= rrf_pkg::RESP_OK;
		end else begin
			if (arvalid && arready) begin
				arready <= 1'b0;
				rvalid  <= 1'b1;
				rdata   <= next_rdata;
				rresp   <= mapped(araddr) ? rrf_pkg::RESP_OK
					: rrf_pkg::RESP_ERR;
			end
			if (rvalid && rready) begin
				rvalid  <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			frame_mode <= rrf_pkg::FR_RAW;
			mod_sel    <= rrf_pkg::MOD_ASK;
			pre_pat    <= rrf_pkg::RST_PRE;
			pre_len    <= rrf_pkg::PLEN_MAX;
			period     <= rrf_pkg::RST_PERIOD;
			brate      <= rrf_pkg::RST_PERIOD;
			fdev       <= 16'h0000;
		end else if (do_wr) begin
			if (wa == rrf_pkg::A_CTRL) begin
				if (ws[0]) begin
					{mod_sel, frame_mode} <= wd[3:0];
				end
			end else if (wa == rrf_pkg::A_PRE) begin
				pre_pat <= merge(pre_pat, wd, ws);
			end else if (wa == rrf_pkg::A_PLEN) begin
				if (ws[0]) begin
					pre_len <= wd[5:0] < rrf_pkg::PLEN_MIN ? rrf_pkg::PLEN_MIN
						: wd[5:0] > rrf_pkg::PLEN_MAX ? rrf_pkg::PLEN_MAX
						: wd[5:0];
				end
			end else if (wa == rrf_pkg::A_PERIOD) begin
				period <= 16'(merge({16'h0000, period}, wd, ws));
			end else if (wa == rrf_pkg::A_BRATE) begin
				brate <= 16'(merge({16'h0000, brate}, wd, ws));
			end else if (wa == rrf_pkg::A_DEV) begin
				fdev <= 16'(merge({16'h0000, fdev}, wd, ws));
			end
		end
	end

	// ----------------------------------------------------------------
	// Power state
	// ----------------------------------------------------------------
	assign next_pwr = rrf_pkg::pwr_decode(wd[3:0]);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			power_state_select <= rrf_pkg::PW_DOWN;
			pwr_state          <= rrf_pkg::PS_DOWN;
		end else if (do_wr && wa == rrf_pkg::A_POWER && ws[0]) begin
			power_state_select <= wd[3:0];
			if (!(pwr_state == rrf_pkg::PS_FTX &&
				(next_pwr == rrf_pkg::PS_DOWN || next_pwr == rrf_pkg::PS_REG
				|| next_pwr == rrf_pkg::PS_STBY))) begin
				pwr_state <= next_pwr;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			supply_rail_nominal <= 1'b0;
			xtal_on             <= 1'b0;
			synth_on            <= 1'b0;
			synth_tx_freq       <= 1'b0;
			rx_on               <= 1'b0;
			tx_on               <= 1'b0;
		end else begin
			supply_rail_nominal <= pwr_state != rrf_pkg::PS_DOWN;
			xtal_on  <= pwr_state != rrf_pkg::PS_DOWN &&
				pwr_state != rrf_pkg::PS_REG;
			synth_on <= pwr_state == rrf_pkg::PS_SRX ||
				pwr_state == rrf_pkg::PS_FRX || pwr_state == rrf_pkg::PS_STX
				|| pwr_state == rrf_pkg::PS_FTX;
			synth_tx_freq <= pwr_state == rrf_pkg::PS_STX ||
				pwr_state == rrf_pkg::PS_FTX;
			rx_on <= pwr_state == rrf_pkg::PS_FRX;
			tx_on <= pwr_state == rrf_pkg::PS_FTX;
		end
	end

	// ----------------------------------------------------------------
	// Bit rate divider and deviation
	// ----------------------------------------------------------------
	assign next_div = div_cnt + 16'h0001;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt  <= 16'h0000;
			bit_tick <= 1'b0;
		end else if (next_div >= period) begin
			div_cnt  <= 16'h0000;
			bit_tick <= 1'b1;
		end else begin
			div_cnt  <= next_div;
			bit_tick <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			deviation_word <= 16'h0000;
			index_ok       <= 1'b0;
		end else begin
			deviation_word <= mod_sel == rrf_pkg::MOD_MSK ? brate >> 2 : fdev;
			index_ok <= {4'h0, fdev} < {brate, 4'h0};
		end
	end

	// ----------------------------------------------------------------
	// Transmit path
	// ----------------------------------------------------------------
	assign dsss     = frame_mode == rrf_pkg::FR_DSSS;
	assign cur_chip = dsss ? tx_sh[7] ^
		rrf_pkg::PN_SEQ[4'(rrf_pkg::CHIP_LAST - chip_idx)] : tx_sh[7];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_hold      <= 8'h00;
			tx_sh        <= 8'h00;
			tx_left      <= 4'h0;
			chip_idx     <= 4'h0;
			tx_full      <= 1'b0;
			tx_busy      <= 1'b0;
			tx_bit       <= 1'b0;
			tx_bit_valid <= 1'b0;
			pa_on        <= 1'b0;
			freq_dev_pos <= 1'b0;
			phase_180    <= 1'b0;
		end else begin
			tx_bit_valid <= 1'b0;
			if (do_wr && wa == rrf_pkg::A_DATA && ws[0] && !tx_full) begin
				tx_hold <= wd[7:0];
				tx_full <= 1'b1;
			end
			if (!tx_on) begin
				tx_busy  <= 1'b0;
				chip_idx <= 4'h0;
				pa_on    <= 1'b0;
			end else if (bit_tick && tx_busy) begin
				// one bit or chip per tick
				tx_bit       <= cur_chip;
				tx_bit_valid <= 1'b1;
				pa_on <= mod_sel != rrf_pkg::MOD_ASK || cur_chip;
				freq_dev_pos <= cur_chip && (mod_sel == rrf_pkg::MOD_FSK ||
					mod_sel == rrf_pkg::MOD_MSK);
				phase_180 <= cur_chip && mod_sel == rrf_pkg::MOD_PSK;
				if (!dsss || chip_idx == rrf_pkg::CHIP_LAST) begin
					chip_idx <= 4'h0;
					tx_sh    <= {tx_sh[6:0], 1'b0};
					tx_left  <= tx_left - 4'h1;
					if (tx_left == 4'h1) begin
						if (tx_full) begin
							tx_sh   <= tx_hold;
							tx_left <= 4'h8;
							tx_full <= 1'b0;
						end else begin
							tx_busy <= 1'b0;
						end
					end
				end else begin
					chip_idx <= chip_idx + 4'h1;
				end
			end else if (bit_tick && tx_full) begin
				tx_sh   <= tx_hold;
				tx_left <= 4'h8;
				tx_busy <= 1'b1;
				tx_full <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Receive path
	// ----------------------------------------------------------------
	assign flush = !rx_on || (do_wr && wa == rrf_pkg::A_CTRL);

	rrf_despread u_desp (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.flush    (flush),
		.chip_stb (dsss && rx_bit_valid),
		.chip_val (rx_bit),
		.bit_stb  (dsp_stb),
		.bit_val  (dsp_bit)
	);

	rrf_deser u_deser (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.flush    (flush),
		.pre_mode (frame_mode != rrf_pkg::FR_RAW),
		.bit_stb  (dsss ? dsp_stb : rx_bit_valid),
		.bit_val  (dsss ? dsp_bit : rx_bit),
		.pattern  (dsss ? rrf_pkg::DSSS_PRE : pre_pat),
		.plen     (dsss ? rrf_pkg::PLEN_MAX : pre_len),
		.byte_stb (byte_stb),
		.byte_val (byte_val),
		.synced   (synced)
	);

	// A byte arriving in the pop cycle wins, so none is lost
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_data  <= 8'h00;
			rx_valid <= 1'b0;
		end else if (byte_stb) begin
			rx_data  <= byte_val;
			rx_valid <= 1'b1;
		end else if (pop) begin
			rx_valid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_bresp;
		awvalid && awready && wvalid && wready |=> ##1 bvalid;
	endproperty
	a_bresp: assert property (p_bresp) else $error("write answer late");
	property p_rdata;
		rvalid && !rready |=> rvalid && $stable(rdata);
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data moved");
	property p_ftx_hold;
		pwr_state == rrf_pkg::PS_FTX && do_wr && wa == rrf_pkg::A_POWER
			&& ws[0] && wd[3:0] == rrf_pkg::PW_DOWN
			|=> pwr_state == rrf_pkg::PS_FTX;
	endproperty
	a_ftx_hold: assert property (p_ftx_hold) else $error("left tx early");
	property p_undef;
		pwr_state != rrf_pkg::PS_FTX && do_wr && wa == rrf_pkg::A_POWER
			&& ws[0] && wd[3:0] == 4'h3 |=> pwr_state == rrf_pkg::PS_DOWN;
	endproperty
	a_undef: assert property (p_undef) else $error("bad code not off");
	property p_rx_only;
		rx_on |-> synth_on && !tx_on && !synth_tx_freq;
	endproperty
	a_rx_only: assert property (p_rx_only) else $error("rx sections");
	property p_ask;
		tx_bit_valid && $past(mod_sel) == rrf_pkg::MOD_ASK |-> pa_on == tx_bit;
	endproperty
	a_ask: assert property (p_ask) else $error("ask mapping");
	property p_msk;
		mod_sel == rrf_pkg::MOD_MSK |=> deviation_word == ($past(brate) >> 2);
	endproperty
	a_msk: assert property (p_msk) else $error("msk deviation");
	property p_off;
		power_state_select == rrf_pkg::PW_DOWN && pwr_state == rrf_pkg::PS_DOWN
			|=> !tx_on && !rx_on && !supply_rail_nominal;
	endproperty
	a_off: assert property (p_off) else $error("not powered down");

	c_write: cover property (do_wr && wa == rrf_pkg::A_DATA);
	c_rxbyte: cover property (byte_stb && dsss);
	c_ftx: cover property (tx_on && tx_bit_valid);
endmodule
`default_nettype wire

// ===== tb/rrf_modem_model.sv
// Demodulator side model feeding received bits
`default_nettype none
module rrf_modem_model (
	input  wire logic aclk,
	output logic      rx_bit,
	output logic      rx_bit_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rx_bit = 1'h0;
		rx_bit_valid = 1'h0;
	end
	// Byte goes out MSB first, one strobe per bit
	task automatic send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			@(posedge aclk);
			rx_bit <= b[i];
			rx_bit_valid <= 1'h1;
			@(posedge aclk);
			rx_bit_valid <= 1'h0;
			// Off-strobe the line must not look valid
			rx_bit <= ~b[i];
			@(posedge aclk);
		end
	endtask
	// Spread a byte: each bit becomes fifteen chips, MSB first
	task automatic spread(input logic [7:0] b);
		logic c;
		for (int i = 7; i >= 0; i--) begin
			for (int j = 14; j >= 0; j--) begin
				c = b[i] ^ rrf_pkg::PN_SEQ[j];
				@(posedge aclk);
				rx_bit <= c;
				rx_bit_valid <= 1'h1;
				@(posedge aclk);
				rx_bit_valid <= 1'h0;
				rx_bit <= ~c;
			end
		end
	endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the raw framer and power control
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'h0, aresetn = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0;
	logic [31:0] wdata = 32'h0, d;
	logic [3:0] wstrb = 4'hf;
	logic [7:0] gain_level_reading = 8'h3c;
	logic [15:0] post_filter_amplitude = 16'h1234;
	logic [15:0] frequency_offset_track = 16'h8001;
	wire logic awready, wready, bvalid, arready, rvalid, tx_bit;
	wire logic tx_bit_valid, pa_on, freq_dev_pos, phase_180;
	wire logic supply_rail_nominal, xtal_on, synth_on, synth_tx_freq;
	wire logic rx_on, tx_on, rx_bit, rx_bit_valid;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [15:0] deviation_word;
	wire logic [5:0] pw = {supply_rail_nominal, xtal_on, synth_on,
		synth_tx_freq, rx_on, tx_on};
	logic [1:0] r;
	logic e1;
	int err_total = 0, checks = 0, cyc = 0, n;
	// Selector code beside expected section enables
	logic [9:0] pt [7] = '{10'h000, 10'h120, 10'h170, 10'h238,
		10'h27a, 10'h0c0, 10'h33c};
	// Address, read data, response
	logic [41:0] rt [6] = '{{8'h18, 32'h3c, 2'h0},
		{8'h1c, 32'h1234, 2'h0}, {8'h20, 32'hffff8001, 2'h0},
		{8'h08, 32'haaaaaaab, 2'h0}, {8'h0c, 32'h20, 2'h0},
		{8'h30, 32'h0, 2'h2}};
	rrf_radio_framer dut (.*);
	rrf_modem_model m (.aclk, .rx_bit, .rx_bit_valid);
	always #5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			err_total++;
			close_out;
		end
	end
	task automatic ck(input logic [31:0] g, e);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic ck6(input logic [5:0] g, e);
		ck({26'h0, g}, {26'h0, e});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		d = rdata;
		r = rresp;
		rready <= 1'h0;
	endtask
	task automatic wait_bit;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (tx_bit_valid !== 1'h1 && n < 50);
		if (tx_bit_valid !== 1'h1) begin
			err_total++;
			$display("mismatch t=%0t no bit strobe", $time);
		end
	endtask
	task automatic pwr(input logic [3:0] c);
		wr(8'h04, {28'h0, c});
		repeat (2) @(posedge aclk);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// ----------------------------------------------------------
	// Table runs, then hand-written cases
	// ----------------------------------------------------------
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		ck(awready, 1'h1);
		ck6(pw, 6'h00);
		$display("test reset done");
		foreach (rt[i]) begin
			rd(rt[i][41:34]);
			ck(d, rt[i][33:2]);
			ck(r, rt[i][1:0]);
		end
		$display("test reads done");
		wr(8'h24, 32'h2);
		wr(8'h00, 32'h0);
		foreach (pt[i]) begin
			pwr(pt[i][9:6]);
			ck6(pw, pt[i][5:0]);
		end
		$display("test power table done");
		wr(8'h10, 32'ha5);
		pwr(4'hd);
		ck6(pw, 6'h3d);
		for (int i = 7; i >= 0; i--) begin
			wait_bit;
			ck(tx_bit, (32'ha5 >> i) & 32'h1);
			ck(pa_on, tx_bit);
		end
		$display("test transmit done");
		// Leaving transmit straight to power down must be ignored
		pwr(4'h0);
		ck6(pw, 6'h3d);
		pwr(4'hc);
		pwr(4'h0);
		ck6(pw, 6'h00);
		$display("test transmit exit done");
		pwr(4'h9);
		m.send(8'h5a);
		repeat (4) @(posedge aclk);
		rd(8'h10);
		ck(d, 32'h5a);
		wr(8'h0c, 32'h8);
		wr(8'h08, 32'hc3);
		wr(8'h00, 32'h1);
		m.send(8'h00);
		m.send(8'hc3);
		m.send(8'h5a);
		repeat (4) @(posedge aclk);
		rd(8'h10);
		ck(d, 32'h5a);
		$display("test receive done");
		// Spread transmit, PSK: chips of a one bit, then a zero bit
		pwr(4'hc);
		// Chip tick runs fifteen times the user bit rate
		wr(8'h00, 32'ha);
		wr(8'h10, 32'h80);
		pwr(4'hd);
		for (int i = 0; i < 30; i++) begin
			wait_bit;
			e1 = (i < 15) ^ rrf_pkg::PN_SEQ[14 - i % 15];
			ck(tx_bit, e1);
			ck(phase_180, tx_bit);
			ck(freq_dev_pos, 1'h0);
		end
		$display("test spread transmit done");
		pwr(4'hc);
		pwr(4'h9);
		m.spread(8'h00);
		m.spread(8'h00);
		m.spread(8'h00);
		m.spread(8'ha7);
		repeat (4) @(posedge aclk);
		rd(8'h14);
		ck(d, 32'h00001018);
		m.spread(8'h3c);
		repeat (4) @(posedge aclk);
		rd(8'h10);
		ck(d, 32'h3c);
		$display("test spread receive done");
		wr(8'h00, 32'hc);
		@(posedge aclk);
		ck(deviation_word, 32'h19);
		wr(8'h2c, 32'h40);
		wr(8'h00, 32'h4);
		@(posedge aclk);
		ck(deviation_word, 32'h40);
		$display("test deviation done");
		close_out;
	end
endmodule
`default_nettype wire
